/* logic/ftwm_slave.sv */
`timescale 1ns/1ps
`include "ftwm_map.svh"

module ftwm_slave
    import ftwm_pkg::*;
#(
    parameter int DATA_W = `FTWM_DATA_BITS,
    parameter int WORD_W = `FTWM_WORD_BITS,
    parameter int PAGE_W = `FTWM_PAGE_BITS,
    parameter int ADDR_W = `FTWM_ADDR_BITS,
    // device type code; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // system clock and power-on reset
    input wire logic CLOCK,
    input wire logic RST,
    // two-wire bus
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // write protect pin
    input wire logic WP
);

    localparam int DEPTH = 1 << ADDR_W;

    generate
        if (ADDR_W != PAGE_W + WORD_W || PAGE_W != `FTWM_PAGE_BITS || DATA_W != 8
            || WORD_W != DATA_W)
        begin : g_bad_geometry
            $error("ftwm_slave: unsupported geometry");
        end
    endgenerate

    // refusal of a write to the upper half under the protect pin
    function automatic logic is_prot(input logic [ADDR_W-1:0] a, input logic wp);
        is_prot = wp && a[ADDR_W-1];
    endfunction : is_prot

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: bits taken on scl rise

    logic bit_tog_r;
    logic bit_val_r;

    always_ff @(posedge SCL or posedge RST)
    begin
        if (RST)
        begin
            bit_tog_r <= 1'h0;
            bit_val_r <= 1'h0;
        end
        else
        begin
            bit_val_r <= SDA_I;
            bit_tog_r <= ~bit_tog_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // crossings into the system domain

    logic scl_s;
    logic sda_s;
    logic tog_s;
    logic wp_s;
    logic scl_d_r;
    logic sda_d_r;
    logic tog_d_r;

    ftwm_sync #(.W(4)) u_sync (
        .clk(CLOCK),
        .rst(RST),
        .d({SCL, SDA_I, bit_tog_r, WP}),
        .q({scl_s, sda_s, tog_s, wp_s})
    );

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            scl_d_r <= 1'h0;
            sda_d_r <= 1'h1;
            tog_d_r <= 1'h0;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            tog_d_r <= tog_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus events

    ftwm_state_t st_r;
    logic [3:0] bitcnt_r;
    logic ack_r;
    logic [7:0] shreg_r;
    logic [7:0] tx_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] mem_r [0:DEPTH-1];
    logic sda_oe_r;
    logic sda_o_r;

    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic fall_ev;
    logic last_bit;
    logic ack_bit;
    logic type_ok;
    logic mem_we;
    logic [7:0] byte_in;

    assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
    assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
    assign bit_ev = (tog_s ^ tog_d_r) && (st_r != ST_IDLE) && !start_ev && !stop_ev;
    assign fall_ev = scl_d_r && !scl_s;
    assign last_bit = bit_ev && (bitcnt_r == `FTWM_BIT_LAST);
    assign ack_bit = bit_ev && (bitcnt_r == `FTWM_ACK_SLOT);
    assign byte_in = {shreg_r[6:0], bit_val_r};
    assign type_ok = byte_in[`FTWM_SA_TYPE_HI:`FTWM_SA_TYPE_LO] == DEV_TYPE;
    // protected writes never reach the array
    assign mem_we = last_bit && (st_r == ST_WRITE) && !is_prot(addr_r, wp_s);

    ////////////////////////////////////////////////////////////////////////////////
    // interface state machine

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            st_r <= ST_IDLE;
            bitcnt_r <= `FTWM_BIT_FIRST;
            ack_r <= 1'h0;
        end
        else if (start_ev)
        begin
            st_r <= ST_SLAVE;
            bitcnt_r <= `FTWM_BIT_FIRST;
            ack_r <= 1'h0;
        end
        else if (stop_ev)
        begin
            st_r <= ST_IDLE;
            bitcnt_r <= `FTWM_BIT_FIRST;
            ack_r <= 1'h0;
        end
        else if (ack_bit)
        begin
            bitcnt_r <= `FTWM_BIT_FIRST;
            ack_r <= 1'h0;
            // master nack ends a read
            if (st_r == ST_READ && bit_val_r)
            begin
                st_r <= ST_IDLE;
            end
        end
        else if (bit_ev)
        begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (last_bit)
            begin
                unique case (st_r)
                    ST_IDLE:
                    begin
                        ack_r <= 1'h0;
                    end
                    ST_SLAVE:
                    begin
                        ack_r <= type_ok;
                        if (!type_ok)
                        begin
                            st_r <= ST_IDLE;
                        end
                        else if (byte_in[`FTWM_SA_RW_BIT] == `FTWM_RW_WRITE)
                        begin
                            st_r <= ST_WORD;
                        end
                        else
                        begin
                            st_r <= ST_READ;
                        end
                    end
                    ST_WORD:
                    begin
                        ack_r <= 1'h1;
                        st_r <= ST_WRITE;
                    end
                    ST_WRITE:
                    begin
                        ack_r <= !is_prot(addr_r, wp_s);
                        if (is_prot(addr_r, wp_s))
                        begin
                            st_r <= ST_IDLE;
                        end
                    end
                    ST_READ:
                    begin
                        ack_r <= 1'h0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive shifter and address latch

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            shreg_r <= 8'h00;
        end
        else if (bit_ev && bitcnt_r != `FTWM_ACK_SLOT)
        begin
            shreg_r <= byte_in;
        end
    end

    // page from slave byte, word from address byte
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            addr_r <= '0;
        end
        else if (last_bit && st_r == ST_SLAVE && type_ok)
        begin
            addr_r[ADDR_W-1:WORD_W] <= byte_in[`FTWM_SA_PAGE_HI:`FTWM_SA_PAGE_LO];
        end
        else if (last_bit && st_r == ST_WORD)
        begin
            addr_r[WORD_W-1:0] <= byte_in;
        end
        else if (mem_we || (last_bit && st_r == ST_READ))
        begin
            addr_r <= addr_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // array

    // write lands on the third system clock edge after the 8th scl rise
    always_ff @(posedge CLOCK)
    begin
        if (mem_we)
        begin
            mem_r[addr_r] <= byte_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit path

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            tx_r <= 8'h00;
        end
        else if (ack_bit && st_r == ST_READ && !bit_val_r)
        begin
            tx_r <= mem_r[addr_r];
        end
        else if (fall_ev && st_r == ST_READ && bitcnt_r != `FTWM_ACK_SLOT)
        begin
            tx_r <= {tx_r[6:0], 1'h0};
        end
    end

    // release outside ack and read data
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            sda_oe_r <= 1'h0;
        end
        else if (start_ev || stop_ev)
        begin
            sda_oe_r <= 1'h0;
        end
        else if (fall_ev)
        begin
            if (st_r != ST_IDLE && bitcnt_r == `FTWM_ACK_SLOT)
            begin
                sda_oe_r <= ack_r;
            end
            else if (st_r == ST_READ)
            begin
                sda_oe_r <= !tx_r[7];
            end
            else
            begin
                sda_oe_r <= 1'h0;
            end
        end
    end

    // sda output level held low; only the enable drives the line
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            sda_o_r <= 1'h0;
        end
        else
        begin
            sda_o_r <= 1'h0;
        end
    end

    assign SDA_OE = sda_oe_r;
    assign SDA_O = sda_o_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_idle_released:
    assert property (@(posedge CLOCK) disable iff (RST) st_r == ST_IDLE |-> !SDA_OE)
    else $error("sda driven while idle");

    a_open_drain:
    assert property (@(posedge CLOCK) disable iff (RST) SDA_OE |-> SDA_O == 1'h0)
    else $error("sda driven high");

    a_start_abort:
    assert property (@(posedge CLOCK) disable iff (RST)
        start_ev |=> st_r == ST_SLAVE && bitcnt_r == `FTWM_BIT_FIRST && !SDA_OE)
    else $error("start did not restart interface");

    a_stop_idle:
    assert property (@(posedge CLOCK) disable iff (RST)
        stop_ev |=> st_r == ST_IDLE && !SDA_OE)
    else $error("stop did not return to idle");

    a_wp_guard:
    assert property (@(posedge CLOCK) disable iff (RST)
        mem_we |-> !(wp_s && addr_r[ADDR_W-1]))
    else $error("write into protected half");

    a_wp_permit:
    assert property (@(posedge CLOCK) disable iff (RST)
        last_bit && st_r == ST_WRITE && !(wp_s && addr_r[ADDR_W-1])
        |=> ack_r && st_r == ST_WRITE)
    else $error("permitted write refused");

    a_prot_nack:
    assert property (@(posedge CLOCK) disable iff (RST)
        last_bit && st_r == ST_WRITE && wp_s && addr_r[ADDR_W-1]
        |=> st_r == ST_IDLE && !ack_r && addr_r == $past(addr_r))
    else $error("protected byte acknowledged or counted");

    a_addr_wrap:
    assert property (@(posedge CLOCK) disable iff (RST)
        mem_we && addr_r == {ADDR_W{1'b1}} |=> addr_r == '0)
    else $error("address did not wrap");

    a_type_reject:
    assert property (@(posedge CLOCK) disable iff (RST)
        last_bit && st_r == ST_SLAVE && !type_ok |=> st_r == ST_IDLE && !ack_r)
    else $error("foreign slave address accepted");

    a_drive_on_fall:
    assert property (@(posedge CLOCK) disable iff (RST)
        $rose(SDA_OE) |-> $past(fall_ev))
    else $error("sda pulled low off a falling edge");

    a_write_done:
    assert property (@(posedge CLOCK) disable iff (RST)
        mem_we |=> mem_r[$past(addr_r)] == $past(byte_in))
    else $error("array write not complete");

endmodule : ftwm_slave

/* logic/ftwm_map.svh */
`ifndef FTWM_MAP_SVH
`define FTWM_MAP_SVH

// slave address byte fields
`define FTWM_SA_TYPE_HI 7
`define FTWM_SA_TYPE_LO 4
`define FTWM_SA_PAGE_HI 3
`define FTWM_SA_PAGE_LO 1
`define FTWM_SA_RW_BIT 0
`define FTWM_RW_WRITE 1'h0

// bit counter positions within one byte frame
`define FTWM_BIT_FIRST 4'h0
`define FTWM_BIT_LAST 4'h7
`define FTWM_ACK_SLOT 4'h8

// documented geometry
`define FTWM_DATA_BITS 8
`define FTWM_WORD_BITS 8
`define FTWM_PAGE_BITS 3
`define FTWM_ADDR_BITS 11

`endif

/* logic/ftwm_pkg.sv */
package ftwm_pkg;

    // interface phases, one-hot
    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_SLAVE = 5'h02,
        ST_WORD = 5'h04,
        ST_WRITE = 5'h08,
        ST_READ = 5'h10
    } ftwm_state_t;

endpackage : ftwm_pkg

/* logic/ftwm_sync.sv */
`timescale 1ns/1ps

module ftwm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // async in, synced out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : ftwm_sync

/* dv/ftwm_master.sv */
`timescale 1ns/1ps

module ftwm_master #(
    parameter int Q = 625
) (
    // bus lines
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);

    initial
    begin
        scl = 1'h1;
        sda_oe = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic start();
        sda_oe = 1'h0;
        #Q scl = 1'h1;
        #Q sda_oe = 1'h1;
        #Q scl = 1'h0;
        #Q;
    endtask : start

    task automatic stop();
        sda_oe = 1'h1;
        #Q scl = 1'h1;
        #Q sda_oe = 1'h0;
        #Q;
    endtask : stop

    // one bit is 4*Q ns, 400 kHz at the default Q of 625
    task automatic pulse(output logic s);
        #Q scl = 1'h1;
        #Q s = sda;
        #Q scl = 1'h0;
        #Q;
    endtask : pulse

    task automatic wbyte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        for (int i = 7; i > 7 - n; i--)
        begin
            sda_oe = ~b[i];
            pulse(s);
        end
        if (n == 8)
        begin
            sda_oe = 1'h0;
            pulse(s);
        end
        ack = ~s;
    endtask : wbyte

    task automatic rbyte(output logic [7:0] b, input logic mack);
        logic s;
        sda_oe = 1'h0;
        for (int i = 7; i >= 0; i--)
        begin
            pulse(s);
            b[i] = s;
        end
        sda_oe = mack;
        pulse(s);
    endtask : rbyte

    task automatic idle_clocks(input int n);
        logic s;
        sda_oe = 1'h0;
        #Q scl = 1'h0;
        repeat (n) pulse(s);
        #Q scl = 1'h1;
        #Q;
    endtask : idle_clocks

endmodule : ftwm_master

/* dv/test_ferroelectric_two_wire_memory_slave.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module test_ferroelectric_two_wire_memory_slave;

    localparam logic [3:0] DEV = 4'h5;
    logic clock = 1'h0;
    logic rst = 1'h0;
    logic wp = 1'h0;
    logic scl;
    logic m_oe;
    logic sda_o;
    logic sda_oe;
    logic sda;
    logic ack;
    logic [7:0] rd;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    always #10 clock = ~clock;

    // wired line with pull-up
    assign sda = ~(m_oe | sda_oe);

    ftwm_slave #(.DEV_TYPE(DEV)) u_ftwm_slave (.CLOCK(clock), .RST(rst), .SCL(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .WP(wp));
    ftwm_master u_ftwm_master (.scl(scl), .sda_oe(m_oe), .sda(sda));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic send(input logic [7:0] b, input logic exp, input string nm);
        u_ftwm_master.wbyte(b, 8, ack);
        `CHK(nm, exp, ack)
        `CHK("sda_o", 1'h0, sda_o)
    endtask : send

    task automatic recv(input logic [7:0] exp, input logic mack, input string nm);
        u_ftwm_master.rbyte(rd, mack);
        `CHK(nm, exp, rd)
    endtask : recv

    task automatic addr(input logic [2:0] pg, input logic [7:0] wd);
        u_ftwm_master.start();
        send({DEV, pg, 1'h0}, 1'h1, "slave ack");
        send(wd, 1'h1, "word ack");
    endtask : addr

    task automatic rd_go(input logic [2:0] pg);
        u_ftwm_master.start();
        send({DEV, pg, 1'h1}, 1'h1, "read ack");
    endtask : rd_go

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        // raised after time zero so the scl-side flops see its edge
        @(negedge clock) rst = 1'h1;
        repeat (5) @(negedge clock);
        rst = 1'h0;
        repeat (4) @(negedge clock);
        `CHK("oe after reset", 1'h0, sda_oe)
        `CHK("sda_o", 1'h0, sda_o)
        $display("test reset done");
    endtask : t_reset

    task automatic t_wrap();
        addr(3'h7, 8'hfe);
        send(8'h11, 1'h1, "data ack");
        send(8'h22, 1'h1, "data ack");
        send(8'h33, 1'h1, "data ack");
        u_ftwm_master.stop();
        addr(3'h7, 8'hfe);
        rd_go(3'h7);
        recv(8'h11, 1'h1, "rd 7fe");
        recv(8'h22, 1'h1, "rd 7ff");
        recv(8'h33, 1'h0, "rd 000");
        u_ftwm_master.stop();
        `CHK("oe idle", 1'h0, sda_oe)
        $display("test wrap done");
    endtask : t_wrap

    task automatic t_type();
        u_ftwm_master.start();
        send({DEV ^ 4'h1, 3'h0, 1'h0}, 1'h0, "bad type");
        send(8'h00, 1'h0, "ignored");
        u_ftwm_master.stop();
        $display("test type done");
    endtask : t_type

    task automatic t_protect();
        addr(3'h4, 8'h10);
        send(8'h77, 1'h1, "data ack");
        send(8'h88, 1'h1, "data ack");
        u_ftwm_master.stop();
        @(negedge clock) wp = 1'h1;
        addr(3'h3, 8'h10);
        send(8'h66, 1'h1, "lower half");
        u_ftwm_master.stop();
        addr(3'h4, 8'h10);
        send(8'h5a, 1'h0, "protected");
        u_ftwm_master.stop();
        rd_go(3'h4);
        recv(8'h77, 1'h0, "no write no inc");
        u_ftwm_master.stop();
        @(negedge clock) wp = 1'h0;
        $display("test protect done");
    endtask : t_protect

    task automatic t_abort();
        addr(3'h2, 8'h20);
        send(8'h99, 1'h1, "data ack");
        u_ftwm_master.stop();
        addr(3'h2, 8'h20);
        u_ftwm_master.wbyte(8'h00, 4, ack);
        u_ftwm_master.stop();
        // clocks with no start: an unaborted byte would land at 220h
        u_ftwm_master.idle_clocks(9);
        addr(3'h2, 8'h20);
        rd_go(3'h2);
        recv(8'h99, 1'h0, "abort kept");
        u_ftwm_master.stop();
        $display("test abort done");
    endtask : t_abort

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    initial
    begin
        t_reset();
        t_wrap();
        t_type();
        t_protect();
        t_abort();
        wrap_up();
    end

endmodule : test_ferroelectric_two_wire_memory_slave
